// *** hw/noise_cancel_mode_control_regs.sv ***
// Notes on behaviour
// R1 - Bits 7:6 pick headphone source, reset 11
// R2 - Software never writes source code 10
// R3 - Bit 5 set disconnects line input
// R4 - Bit 1 enables left first opamp
// R5 - Bit 0 enables right first opamp
// R6 - Left gain bits 6:0, reset 57h
// R7 - Software never writes left gain 3Fh
// R8 - Left code 57h mutes with attenuation
// R9 - Code 7Fh mutes without attenuation
// R10 - Right gain bits 6:0, reset 57h
// R11 - Right attenuation mute code taken as 57h
// R12 - Readback of fields, undefined bits zero
module noise_cancel_mode_control_regs (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // Register port
    input  wire logic [7:0]                  addr,
    input  wire logic [7:0]                  wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [7:0]                  rdata,
    // Mode input from elsewhere
    input  wire logic                        negative_attenuation_enable,
    // Routing, gain and reserved source flag outputs
    output nc_regs_pkg::route_out_t          route,
    output nc_regs_pkg::mic_gain_out_t       left_microphone_gain,
    output nc_regs_pkg::mic_gain_out_t       right_microphone_gain,
    output logic                             reserved_source_seen
);
    logic [7:0] mode;
    logic [6:0] left_gain;
    logic [6:0] right_gain;
    logic [7:0] next_rdata;

    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= {nc_regs_pkg::SRC_RESET, 6'h00}; // R1 R3 R4 R5
        end else if (wr && addr == nc_regs_pkg::MODE_OFFSET) begin
            mode <= wdata & nc_regs_pkg::MODE_MASK; // R12
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            left_gain <= nc_regs_pkg::GAIN_RESET; // R6
        end else if (wr && addr == nc_regs_pkg::LEFT_OFFSET) begin
            left_gain <= wdata[6:0]; // R6
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            right_gain <= nc_regs_pkg::GAIN_RESET; // R10
        end else if (wr && addr == nc_regs_pkg::RIGHT_OFFSET) begin
            right_gain <= wdata[6:0]; // R10
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (addr)
            nc_regs_pkg::MODE_OFFSET:  next_rdata = mode; // R12
            nc_regs_pkg::LEFT_OFFSET:  next_rdata = {1'b0, left_gain}; // R12
            nc_regs_pkg::RIGHT_OFFSET: next_rdata = {1'b0, right_gain}; // R12
            default:                   next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

    // Flags software writing reserved source code
    always_ff @(posedge clk) begin
        if (srst) begin
            reserved_source_seen <= 1'b0;
        end else begin
            reserved_source_seen <= (mode[7:6] == nc_regs_pkg::SRC_RESERVED); // R2
        end
    end

    route_decode u_route (
        .mode  (mode),
        .route (route)
    );

    mic_gain_decode u_left (
        .code                        (left_gain),
        .negative_attenuation_enable (negative_attenuation_enable),
        .result                      (left_microphone_gain)
    );

    mic_gain_decode u_right (
        .code                        (right_gain),
        .negative_attenuation_enable (negative_attenuation_enable),
        .result                      (right_microphone_gain)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence mode_write_s;
        wr && addr == nc_regs_pkg::MODE_OFFSET;
    endsequence

    source_reset_a: assert property ($fell(srst) |-> route.headphone_source_select == 2'h3) // R1
        else $error("source not 11 after reset");
    source_write_a: assert property (mode_write_s |=> route.headphone_source_select == $past(wdata[7:6])) // R1
        else $error("source not written");
    line_mute_a: assert property (mode_write_s |=> route.line_pass == !$past(wdata[5])) // R3
        else $error("line mute wrong");
    left_opamp_a: assert property (mode_write_s |=> route.left_first_opamp_enable == $past(wdata[1])) // R4
        else $error("left opamp wrong");
    right_opamp_a: assert property (mode_write_s |=> route.right_first_opamp_enable == $past(wdata[0])) // R5
        else $error("right opamp wrong");
    left_gain_a: assert property (wr && addr == nc_regs_pkg::LEFT_OFFSET |=> left_microphone_gain.gain == $past(wdata[6:0])) // R6
        else $error("left gain not written");
    neg_mute_a: assert property (negative_attenuation_enable && left_gain == 7'h57 |-> left_microphone_gain.mute) // R8
        else $error("left mute missing");
    plain_mute_a: assert property (!negative_attenuation_enable |-> right_microphone_gain.mute == (right_gain == 7'h7F)) // R9
        else $error("right mute wrong");
    right_reset_a: assert property ($fell(srst) |-> right_gain == 7'h57) // R10
        else $error("right gain reset wrong");
    readback_a: assert property (rd && addr == nc_regs_pkg::LEFT_OFFSET |=> rdata == {1'b0, $past(left_gain)}) // R12
        else $error("readback wrong");
    unmapped_a: assert property (rd && addr > nc_regs_pkg::RIGHT_OFFSET |=> rdata == 8'h00) // R12
        else $error("unmapped read not zero");
endmodule

// *** hw/nc_regs_pkg.sv ***
package nc_regs_pkg;
    localparam int        ADDR_W          = 8;
    localparam int        DATA_W          = 8;
    localparam int        GAIN_W          = 7;
    localparam logic [7:0] MODE_OFFSET    = 8'h0A;
    localparam logic [7:0] LEFT_OFFSET    = 8'h0B;
    localparam logic [7:0] RIGHT_OFFSET   = 8'h0C;
    localparam int        SRC_MSB         = 7;
    localparam int        SRC_LSB         = 6;
    localparam int        LINE_MUTE_BIT   = 5;
    localparam int        LEFT_OPAMP_BIT  = 1;
    localparam int        RIGHT_OPAMP_BIT = 0;
    localparam logic [1:0] SRC_RESET      = 2'h3;
    localparam logic [6:0] GAIN_RESET     = 7'h57;
    localparam logic [6:0] GAIN_MAX_CODE  = 7'h3E;
    localparam logic [6:0] GAIN_UNUSABLE  = 7'h3F;
    localparam logic [6:0] MUTE_NEG_ATT   = 7'h57;
    localparam logic [6:0] MUTE_NO_ATT    = 7'h7F;
    localparam logic [7:0] MODE_MASK      = 8'hE3;

    typedef enum logic [1:0] {
        SRC_QUIET_MIC = 2'b00,
        SRC_OPAMP     = 2'b01,
        SRC_RESERVED  = 2'b10,
        SRC_NONE      = 2'b11
    } headphone_source_t;

    typedef struct packed {
        logic [6:0] gain;
        logic       mute;
        logic       in_range;
    } mic_gain_out_t;

    typedef struct packed {
        logic [1:0] headphone_source_select;
        logic       line_pass;
        logic       left_first_opamp_enable;
        logic       right_first_opamp_enable;
        logic       quiet_microphone_path_on;
        logic       first_operational_amplifier_path_on;
    } route_out_t;
endpackage

// *** hw/mic_gain_decode.sv ***
module mic_gain_decode (
    // Gain code and attenuation mode
    input  wire logic [6:0]                  code,
    input  wire logic                        negative_attenuation_enable,
    // Decoded gain
    output nc_regs_pkg::mic_gain_out_t       result
);
    always_comb begin
        result.gain = code;
        result.mute = negative_attenuation_enable ? (code == nc_regs_pkg::MUTE_NEG_ATT) // R8 R11
                                                  : (code == nc_regs_pkg::MUTE_NO_ATT); // R9
        result.in_range = (code <= nc_regs_pkg::GAIN_MAX_CODE); // R6 R10
    end
endmodule

// *** hw/route_decode.sv ***
module route_decode (
    // Mode register value
    input  wire logic [7:0]                  mode,
    // Analog routing controls
    output nc_regs_pkg::route_out_t          route
);
    always_comb begin
        route.headphone_source_select = mode[nc_regs_pkg::SRC_MSB:nc_regs_pkg::SRC_LSB];
        route.line_pass = ~mode[nc_regs_pkg::LINE_MUTE_BIT]; // R3
        route.left_first_opamp_enable = mode[nc_regs_pkg::LEFT_OPAMP_BIT]; // R4
        route.right_first_opamp_enable = mode[nc_regs_pkg::RIGHT_OPAMP_BIT]; // R5
        route.quiet_microphone_path_on = (route.headphone_source_select == nc_regs_pkg::SRC_QUIET_MIC); // R1
        route.first_operational_amplifier_path_on = (route.headphone_source_select == nc_regs_pkg::SRC_OPAMP); // R1
    end
endmodule

// *** tb/test_noise_cancel_mode_control_regs.sv ***
module test_noise_cancel_mode_control_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        clk = 1'b0;
    logic                        srst = 1'b1;
    logic                        wr = 1'b0;
    logic                        rd = 1'b0;
    logic                        nae = 1'b0;
    logic [7:0]                  addr = 8'h00;
    logic [7:0]                  wdata = 8'h00;
    logic [7:0]                  rdata;
    logic [7:0]                  lfsr = 8'h56;
    logic [7:0]                  m_s, l_s, r_s;
    logic                        rd_q = 1'b0;
    logic                        rsv_e = 1'b0;
    logic                        rsv;
    logic [7:0]                  exp_q[$];
    logic [6:0]                  codes[5] = '{7'h00, 7'h3E, 7'h3F, 7'h57, 7'h7F};
    nc_regs_pkg::route_out_t     route;
    nc_regs_pkg::mic_gain_out_t  lg, rg;
    int                          n_errors = 0;
    int                          n_compared = 0;

    always #25 clk = ~clk;

    noise_cancel_mode_control_regs dut (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .negative_attenuation_enable(nae), .route(route), .left_microphone_gain(lg),
        .right_microphone_gain(rg), .reserved_source_seen(rsv));

    function automatic logic [7:0] nxt(input logic [7:0] l);
        return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
    endfunction
    // Keeps stimulus off the reserved source code and the unusable left gain code
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h0A && d[7:6] == 2'b10) return d | 8'h40;
        if (a == 8'h0B && d[6:0] == 7'h3F) return d ^ 8'h01;
        return d;
    endfunction
    function automatic logic [8:0] exp_gain(input logic [7:0] c);
        return {c[6:0], (c[6:0] == 7'h7F && !nae) || (c[6:0] == 7'h57 && nae), c[6:0] <= 7'h3E};
    endfunction
    function automatic logic [6:0] exp_route(input logic [7:0] m);
        return {m[7:6], !m[5], m[1], m[0], m[7:6] == 2'b00, m[7:6] == 2'b01};
    endfunction

    task automatic check(input logic [8:0] seen, input logic [8:0] expv);
        n_compared++;
        if (seen !== expv) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic conclude;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk); addr <= a; rd <= 1'b1; wr <= 1'b0;
    endtask
    task automatic idle;
        @(posedge clk); wr <= 1'b0; rd <= 1'b0;
    endtask

    // Reference copy of the registers, noting each read result
    always @(posedge clk) begin
        rd_q <= rd && !srst;
        rsv_e <= !srst && m_s[7:6] == 2'b10;
        if (srst) begin
            m_s <= 8'hC0; l_s <= 8'h57; r_s <= 8'h57; exp_q.delete();
        end else if (wr) begin
            if (addr == 8'h0A) m_s <= wdata & 8'hE3;
            if (addr == 8'h0B) l_s <= {1'b0, wdata[6:0]};
            if (addr == 8'h0C) r_s <= {1'b0, wdata[6:0]};
        end else if (rd) begin
            exp_q.push_back(addr == 8'h0A ? m_s : addr == 8'h0B ? l_s : addr == 8'h0C ? r_s : 8'h00);
        end
    end

    // Output watcher
    always @(negedge clk) begin
        if (!srst) begin
            if (rd_q && exp_q.size() > 0) check({1'b0, rdata}, {1'b0, exp_q.pop_front()});
            else check({1'b0, rdata}, 9'h000);
            check({2'b00, route}, {2'b00, exp_route(m_s)});
            check(lg, exp_gain(l_s));
            check(rg, exp_gain(r_s));
            check({8'h00, rsv}, {8'h00, rsv_e});
        end
    end

    initial begin
        #250000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) rd_reg(8'h0A + 8'(i));
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h0A, legal(8'h0A, {s[1:0], 6'h3F ^ {s[1:0], 4'h0}}));
            rd_reg(8'h0A);
            idle();
        end
        for (int n = 0; n < 2; n++) begin
            idle();
            nae <= n[0];
            for (int c = 0; c < 5; c++) begin
                wr_reg(8'h0B, legal(8'h0B, {1'b1, codes[c]}));
                wr_reg(8'h0C, {1'b1, codes[4 - c]});
                rd_reg(8'h0B);
                rd_reg(8'h0C);
                idle();
            end
        end
        wr_reg(8'h0D, 8'hFF);
        rd_reg(8'h0D);
        rd_reg(8'h09);
        repeat (60) begin
            lfsr = nxt(lfsr);
            wr_reg(8'h09 + {5'h00, lfsr[2:0]}, legal(8'h09 + {5'h00, lfsr[2:0]}, nxt(lfsr)));
            rd_reg(8'h09 + {5'h00, lfsr[2:0]});
            idle();
            nae <= lfsr[7];
        end
        srst <= 1'b1;
        idle();
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) rd_reg(8'h0A + 8'(i));
        idle();
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule
